// >>> hdl/cksyn_cfg_if.sv
// Signals between the register bank and its halt and pin controllers
`timescale 1ns/1ps
interface cksyn_cfg_if import cksyn_pkg::*; ();
    logic [NUM_OUT-1:0] halt_req;
    logic global_halt;
    logic [NUM_OUT*HALT_SRC_W-1:0] halt_src;
    logic [NUM_OUT-1:0] out_halt;
    logic [NUM_PIN*MODE_W-1:0] pin_modes;
    logic [NUM_PIN*PICK_W-1:0] pin_picks;
    logic [STATUS_W-1:0] status_bank;
    logic [NUM_PIN-1:0] pin_in;
    logic [NUM_PIN-1:0] pin_out;
    logic [NUM_PIN-1:0] pin_oe;
    logic [NUM_PIN-1:0] pin_state;

    modport regs (output halt_req, global_halt, halt_src, pin_modes, pin_picks, status_bank,
        pin_in, input out_halt, pin_out, pin_oe, pin_state);
    modport halt (input halt_req, global_halt, halt_src, output out_halt);
    modport pin (input pin_modes, pin_picks, status_bank, pin_in,
        output pin_out, pin_oe, pin_state);
endinterface

// >>> hdl/cksyn_cfg_top.sv
// Global configuration register bank of the clock synthesizer
`timescale 1ns/1ps
module cksyn_cfg_top import cksyn_pkg::*; #(
    parameter logic [SEL_REG_W-1:0] LOOP_IRQ_MASK_IDX = 5'h1F
) (
    input logic clk,
    input logic rst,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input logic global_output_halt,
    input logic [NUM_OUT*HALT_SRC_W-1:0] halt_source_select,
    input logic [STATUS_W-1:0] status_bank,
    input logic [NUM_PIN-1:0] pin_in,
    output logic [NUM_PIN-1:0] pin_out,
    output logic [NUM_PIN-1:0] pin_oe,
    output logic synth_loop_on,
    output logic [NUM_IN-1:0] input_on,
    output logic [NUM_OUT-1:0] output_n_on,
    output logic [GRP_W*SRC_W-1:0] group_source,
    output logic [NUM_OUT-1:0] output_halt
);
    cksyn_regs_s st;
    cksyn_regs_s next;
    logic pick_hit;

    cksyn_cfg_if cfg ();

    cksyn_halt_ctl u_halt (
        .clk(clk),
        .rst(rst),
        .cfg(cfg.halt)
    );

    cksyn_pin_ctl #(
        .LOOP_IRQ_MASK_IDX(LOOP_IRQ_MASK_IDX)
    ) u_pin (
        .clk(clk),
        .rst(rst),
        .cfg(cfg.pin)
    );

    assign pick_hit = (reg_addr >= ADDR_PICK0) && (reg_addr <= ADDR_PICK3);

    always_comb begin
        logic [1:0] pick_idx;
        pick_idx = 2'(reg_addr - ADDR_PICK0);
        next = st;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_LOOP_EN: next.loop_en = reg_wdata & MASK_LOOP_EN;
                ADDR_IN_EN: next.in_en = reg_wdata & MASK_IN_EN;
                ADDR_OUT_EN_LO: next.out_en_lo = reg_wdata;
                ADDR_OUT_EN_HI: next.out_en_hi = reg_wdata & MASK_OUT_EN_HI;
                ADDR_SRC_ABC: next.src_abc = reg_wdata & MASK_SRC;
                ADDR_SRC_DEF: next.src_def = reg_wdata & MASK_SRC;
                ADDR_HALT_LO: next.halt_lo = reg_wdata;
                ADDR_HALT_HI: next.halt_hi = reg_wdata & MASK_HALT_HI;
                ADDR_MODE_01: next.mode_01 = reg_wdata;
                ADDR_MODE_23: next.mode_23 = reg_wdata;
                default: ;
            endcase
            if (pick_hit) begin
                next.pick[pick_idx*PICK_W +: PICK_W] = reg_wdata;
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_LOOP_EN: next.rdata = st.loop_en;
                ADDR_IN_EN: next.rdata = st.in_en;
                ADDR_OUT_EN_LO: next.rdata = st.out_en_lo;
                ADDR_OUT_EN_HI: next.rdata = st.out_en_hi;
                ADDR_SRC_ABC: next.rdata = st.src_abc;
                ADDR_SRC_DEF: next.rdata = st.src_def;
                ADDR_HALT_LO: next.rdata = st.halt_lo;
                ADDR_HALT_HI: next.rdata = st.halt_hi;
                ADDR_MODE_01: next.rdata = st.mode_01;
                ADDR_MODE_23: next.rdata = st.mode_23;
                ADDR_PIN_STATE: next.rdata = {{(BYTE_W-NUM_PIN){1'b0}}, cfg.pin_state};
                default: next.rdata = RESET_BYTE;
            endcase
            if (pick_hit) begin
                next.rdata = st.pick[pick_idx*PICK_W +: PICK_W];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next;
        end
    end

    // Feeds to the halt and pin controllers
    assign cfg.halt_req = {st.halt_hi[NUM_OUT-NUM_OUT_LO-1:0], st.halt_lo};
    assign cfg.global_halt = global_output_halt;
    assign cfg.halt_src = halt_source_select;
    assign cfg.pin_modes = {st.mode_23, st.mode_01};
    assign cfg.pin_picks = st.pick;
    assign cfg.status_bank = status_bank;
    assign cfg.pin_in = pin_in;

    // Registered outputs
    assign reg_rdata = st.rdata;
    assign synth_loop_on = st.loop_en[0];
    assign input_on = st.in_en[NUM_IN-1:0];
    assign output_n_on = {st.out_en_hi[NUM_OUT-NUM_OUT_LO-1:0], st.out_en_lo};
    assign group_source = {st.src_def[GRP_W-1:0], st.src_abc[GRP_W-1:0]};
    assign output_halt = cfg.out_halt;
    assign pin_out = cfg.pin_out;
    assign pin_oe = cfg.pin_oe;

    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence

    sequence s_rd(logic [7:0] a);
        reg_rd && !reg_wr && reg_addr == a;
    endsequence

    property p_loop_en;
        @(posedge clk) disable iff (rst)
        s_wr(ADDR_LOOP_EN) |=> synth_loop_on == $past(reg_wdata[0]);
    endproperty
    a_loop_en: assert property (p_loop_en) else $error("loop enable not taken");

    property p_loop_hold;
        @(posedge clk) disable iff (rst)
        !(reg_wr && reg_addr == ADDR_LOOP_EN) |=> $stable(synth_loop_on);
    endproperty
    a_loop_hold: assert property (p_loop_hold) else $error("loop enable moved");

    property p_in_en;
        @(posedge clk) disable iff (rst)
        s_wr(ADDR_IN_EN) |=> input_on == $past(reg_wdata[NUM_IN-1:0]);
    endproperty
    a_in_en: assert property (p_in_en) else $error("input enables not taken");

    property p_out_en;
        @(posedge clk) disable iff (rst)
        s_wr(ADDR_OUT_EN_HI) |=> output_n_on[NUM_OUT-1:NUM_OUT_LO] == $past(reg_wdata[1:0]);
    endproperty
    a_out_en: assert property (p_out_en) else $error("outputs 9 and 10 wrong");

    property p_src_abc;
        @(posedge clk) disable iff (rst)
        s_wr(ADDR_SRC_ABC) |=> group_source[GRP_W-1:0] == $past(reg_wdata[GRP_W-1:0]);
    endproperty
    a_src_abc: assert property (p_src_abc) else $error("groups A to C wrong");

    property p_src_def;
        @(posedge clk) disable iff (rst)
        s_wr(ADDR_SRC_DEF) |=> group_source[2*GRP_W-1:GRP_W] == $past(reg_wdata[GRP_W-1:0]);
    endproperty
    a_src_def: assert property (p_src_def) else $error("groups D to F wrong");

    property p_halt_rd;
        @(posedge clk) disable iff (rst)
        s_wr(ADDR_HALT_LO) ##1 s_rd(ADDR_HALT_LO) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_halt_rd: assert property (p_halt_rd) else $error("halt register readback");

    property p_pin_rd;
        @(posedge clk) disable iff (rst)
        s_rd(ADDR_PIN_STATE) |=> reg_rdata == {4'h0, $past(cfg.pin_state)};
    endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("pin state readback");
endmodule // cksyn_cfg_top

// >>> hdl/cksyn_halt_ctl.sv
// Per-output halt control gating
`timescale 1ns/1ps
module cksyn_halt_ctl import cksyn_pkg::*; (
    input logic clk,
    input logic rst,
    cksyn_cfg_if.halt cfg
);
    typedef struct packed {
        logic [NUM_OUT-1:0] halt;
    } cksyn_halt_s;

    cksyn_halt_s st;
    cksyn_halt_s next;

    always_comb begin
        next = st;
        for (int i = 0; i < NUM_OUT; i++) begin
            next.halt[i] = (cfg.halt_src[i*HALT_SRC_W +: HALT_SRC_W] == HALT_SRC_REG)
                && (cfg.halt_req[i] || cfg.global_halt);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next;
        end
    end

    assign cfg.out_halt = st.halt;

    property p_src_gate;
        @(posedge clk) disable iff (rst)
        cfg.halt_src[HALT_SRC_W-1:0] != HALT_SRC_REG |=> !cfg.out_halt[0];
    endproperty
    a_src_gate: assert property (p_src_gate) else $error("halt without register source");

    property p_global;
        @(posedge clk) disable iff (rst)
        cfg.global_halt && cfg.halt_src[NUM_OUT*HALT_SRC_W-1 -: HALT_SRC_W] == HALT_SRC_REG
            |=> cfg.out_halt[NUM_OUT-1];
    endproperty
    a_global: assert property (p_global) else $error("global halt not applied");

    property p_or;
        @(posedge clk) disable iff (rst)
        cfg.halt_req[0] && !cfg.global_halt && cfg.halt_src[HALT_SRC_W-1:0] == HALT_SRC_REG
            |=> cfg.out_halt[0];
    endproperty
    a_or: assert property (p_or) else $error("own halt bit not applied");
endmodule // cksyn_halt_ctl

// >>> hdl/cksyn_pin_ctl.sv
// Mode decode and drive of the four general-purpose pins
`timescale 1ns/1ps
module cksyn_pin_ctl import cksyn_pkg::*; #(
    parameter logic [SEL_REG_W-1:0] LOOP_IRQ_MASK_IDX = 5'h1F
) (
    input logic clk,
    input logic rst,
    cksyn_cfg_if.pin cfg
);
    typedef struct packed {
        logic [NUM_PIN-1:0] drive;
        logic [NUM_PIN-1:0] oe;
        logic [NUM_PIN-1:0] state;
    } cksyn_pin_s;

    cksyn_pin_s st;
    cksyn_pin_s next;
    logic [NUM_PIN-1:0] sbit;

    genvar g;
    generate
        for (g = 0; g < NUM_PIN; g++) begin : g_pick
            logic [SEL_REG_W-1:0] preg;
            assign preg = cfg.pin_picks[g*PICK_W+SEL_BIT_W +: SEL_REG_W];
            // Pin state and loop mask bits never reach a pin
            assign sbit[g] = (preg == PIN_STATE_IDX || preg == LOOP_IRQ_MASK_IDX) ? 1'b0
                : cfg.status_bank[cfg.pin_picks[g*PICK_W +: PICK_W]];
        end
    endgenerate

    always_comb begin
        next = st;
        for (int i = 0; i < NUM_PIN; i++) begin
            next.state[i] = cfg.pin_in[i];
            next.drive[i] = 1'b0;
            next.oe[i] = 1'b0;
            case (cfg.pin_modes[i*MODE_W +: MODE_W])
                PM_IN: ;
                PM_IN_INV: next.state[i] = !cfg.pin_in[i];
                PM_OUT_LOW: next.oe[i] = 1'b1;
                PM_OUT_HIGH: begin
                    next.oe[i] = 1'b1;
                    next.drive[i] = 1'b1;
                end
                PM_ST: begin
                    next.oe[i] = 1'b1;
                    next.drive[i] = sbit[i];
                end
                PM_ST_INV: begin
                    next.oe[i] = 1'b1;
                    next.drive[i] = !sbit[i];
                end
                PM_ST_LOW0: next.oe[i] = !sbit[i];
                PM_ST_LOW1: next.oe[i] = sbit[i];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next;
        end
    end

    assign cfg.pin_out = st.drive;
    assign cfg.pin_oe = st.oe;
    assign cfg.pin_state = st.state;

    property p_inv_in;
        @(posedge clk) disable iff (rst)
        cfg.pin_modes[MODE_W-1:0] == PM_IN_INV |=> cfg.pin_state[0] == !$past(cfg.pin_in[0]);
    endproperty
    a_inv_in: assert property (p_inv_in) else $error("inverted input not inverted");

    property p_drive_hi;
        @(posedge clk) disable iff (rst)
        cfg.pin_modes[MODE_W-1:0] == PM_OUT_HIGH |=> cfg.pin_oe[0] && cfg.pin_out[0];
    endproperty
    a_drive_hi: assert property (p_drive_hi) else $error("pin not driven high");

    property p_blocked;
        @(posedge clk) disable iff (rst)
        cfg.pin_modes[MODE_W-1:0] == PM_ST
            && cfg.pin_picks[PICK_W-1:SEL_BIT_W] == PIN_STATE_IDX
            |=> cfg.pin_oe[0] && !cfg.pin_out[0];
    endproperty
    a_blocked: assert property (p_blocked) else $error("pin state bit routed to pin");

    property p_follow;
        @(posedge clk) disable iff (rst)
        cfg.pin_modes[MODE_W-1:0] == PM_ST_INV
            && cfg.pin_picks[PICK_W-1:SEL_BIT_W] != PIN_STATE_IDX
            && cfg.pin_picks[PICK_W-1:SEL_BIT_W] != LOOP_IRQ_MASK_IDX
            |=> cfg.pin_out[0] == !$past(cfg.status_bank[cfg.pin_picks[PICK_W-1:0]]);
    endproperty
    a_follow: assert property (p_follow) else $error("status output wrong");

    property p_open_drain;
        @(posedge clk) disable iff (rst)
        cfg.pin_modes[MODE_W-1:0] == PM_ST_LOW0 && sbit[0] |=> !cfg.pin_oe[0];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin not released");
endmodule // cksyn_pin_ctl

// >>> hdl/cksyn_pkg.sv
// Constants, codes and state layout of the synthesizer configuration bank
package cksyn_pkg;
    localparam int NUM_IN = 3;
    localparam int NUM_OUT = 10;
    localparam int NUM_OUT_LO = 8;
    localparam int NUM_PIN = 4;
    localparam int BYTE_W = 8;
    localparam int SRC_W = 2;
    localparam int GRP_W = 6;
    localparam int HALT_SRC_W = 4;
    localparam int MODE_W = 4;
    localparam int PICK_W = 8;
    localparam int SEL_REG_W = 5;
    localparam int SEL_BIT_W = 3;
    localparam int STATUS_W = 256;

    localparam logic [7:0] ADDR_LOOP_EN = 8'h03;
    localparam logic [7:0] ADDR_IN_EN = 8'h04;
    localparam logic [7:0] ADDR_OUT_EN_LO = 8'h05;
    localparam logic [7:0] ADDR_OUT_EN_HI = 8'h06;
    localparam logic [7:0] ADDR_SRC_ABC = 8'h07;
    localparam logic [7:0] ADDR_SRC_DEF = 8'h08;
    localparam logic [7:0] ADDR_HALT_LO = 8'h09;
    localparam logic [7:0] ADDR_HALT_HI = 8'h0A;
    localparam logic [7:0] ADDR_MODE_01 = 8'h0B;
    localparam logic [7:0] ADDR_MODE_23 = 8'h0C;
    localparam logic [7:0] ADDR_PICK0 = 8'h0D;
    localparam logic [7:0] ADDR_PICK3 = 8'h10;
    localparam logic [7:0] ADDR_PIN_STATE = 8'h41;

    localparam logic [7:0] MASK_LOOP_EN = 8'h01;
    localparam logic [7:0] MASK_IN_EN = 8'h07;
    localparam logic [7:0] MASK_OUT_EN_HI = 8'h03;
    localparam logic [7:0] MASK_SRC = 8'h3F;
    localparam logic [7:0] MASK_HALT_HI = 8'h03;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    localparam logic [SEL_REG_W-1:0] PIN_STATE_IDX = 5'h01;
    localparam logic [HALT_SRC_W-1:0] HALT_SRC_REG = 4'h1;

    typedef enum logic [1:0] {
        SRC_INT_DIV = 2'b00,
        SRC_FRAC_DIV = 2'b01,
        SRC_UNUSED = 2'b10,
        SRC_PATH_TWO = 2'b11
    } cksyn_src_e;

    typedef enum logic [3:0] {
        PM_IN = 4'h0,
        PM_IN_INV = 4'h1,
        PM_OUT_LOW = 4'h2,
        PM_OUT_HIGH = 4'h3,
        PM_ST = 4'h4,
        PM_ST_INV = 4'h5,
        PM_ST_LOW0 = 4'h6,
        PM_ST_LOW1 = 4'h7
    } cksyn_mode_e;

    typedef struct packed {
        logic [7:0] loop_en;
        logic [7:0] in_en;
        logic [7:0] out_en_lo;
        logic [7:0] out_en_hi;
        logic [7:0] src_abc;
        logic [7:0] src_def;
        logic [7:0] halt_lo;
        logic [7:0] halt_hi;
        logic [7:0] mode_01;
        logic [7:0] mode_23;
        logic [31:0] pick;
        logic [7:0] rdata;
    } cksyn_regs_s;
endpackage

// >>> test/tb_top.sv
// Self-checking bench of the synthesizer configuration bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) begin \
            $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
            err_count++; \
        end \
    end
module tb_top import cksyn_pkg::*;;
    logic clk, rst, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic global_output_halt;
    logic [NUM_OUT*HALT_SRC_W-1:0] halt_source_select;
    logic [STATUS_W-1:0] status_bank;
    logic [NUM_PIN-1:0] pin_in, pin_out, pin_oe;
    logic synth_loop_on;
    logic [NUM_IN-1:0] input_on;
    logic [NUM_OUT-1:0] output_n_on, output_halt;
    logic [GRP_W*SRC_W-1:0] group_source;
    int err_count, checks;
    logic [7:0] masks [8] = '{8'h01, 8'h07, 8'hFF, 8'h03, 8'h3F, 8'h3F, 8'hFF, 8'h03};
    logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};

    cksyn_cfg_top #(.LOOP_IRQ_MASK_IDX(5'h1F)) dut_u (.clk(clk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .global_output_halt(global_output_halt),
        .halt_source_select(halt_source_select), .status_bank(status_bank),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .synth_loop_on(synth_loop_on),
        .input_on(input_on), .output_n_on(output_n_on), .group_source(group_source),
        .output_halt(output_halt));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic idle(input int n);
        reg_wr = 1'b0;
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        // Strobe stays up for a following write; idle and rdchk lower it
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] ex);
        reg_wr = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        `CHK($sformatf("rdata@%0h", a), ex, reg_rdata)
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bank at reset state: all outputs idle, all registers zero
    task automatic reset_chk();
        int a;
        `CHK("loop", 1'b0, synth_loop_on)
        `CHK("inputs", 3'h0, input_on)
        `CHK("outs", 10'h000, output_n_on)
        `CHK("groups", 12'h000, group_source)
        `CHK("halt", 10'h000, output_halt)
        `CHK("oe", 4'h0, pin_oe)
        for (a = 3; a <= 16; a++) begin
            rdchk(a[7:0], 8'h00);
        end
        rdchk(8'h41, 8'h00);
    endtask

    function automatic logic [9:0] halt_exp(input logic [9:0] bits, input logic g);
        int k;
        for (k = 0; k < 10; k++) begin
            halt_exp[k] = (halt_source_select[4*k+:4] == 4'h1) && (bits[k] || g);
        end
    endfunction

    initial begin
        #(20000 * 5);
        err_count++;
        end_sim();
    end

    initial begin
        int a, i, p, m, s;
        logic eoe, eout;
        rst = 1'b1;
        {reg_rd, global_output_halt} = 2'b00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        halt_source_select = '0;
        status_bank = '0;
        pin_in = 4'h0;
        idle(2);
        rst = 1'b0;
        idle(1);
        reset_chk();
        // Reserved bits read back as zero
        for (a = 3; a <= 10; a++) begin
            wr(a[7:0], 8'hFF);
            rdchk(a[7:0], masks[a-3]);
        end
        idle(2);
        `CHK("loop", 1'b1, synth_loop_on)
        `CHK("inputs", 3'h7, input_on)
        `CHK("outs", 10'h3FF, output_n_on)
        wr(8'h03, 8'hFE);
        wr(8'h04, 8'h05);
        wr(8'h05, 8'hA5);
        wr(8'h06, 8'h02);
        idle(2);
        `CHK("loop", 1'b0, synth_loop_on)
        `CHK("inputs", 3'h5, input_on)
        `CHK("outs", 10'h2A5, output_n_on)
        // Unmapped place ignores writes and reads zero
        wr(8'h20, 8'hFF);
        rdchk(8'h20, 8'h00);
        rdchk(8'h11, 8'h00);
        for (i = 0; i < 3; i++) begin
            wr(8'h07, {2'b00, codes[i], codes[i], codes[i]});
            wr(8'h08, {2'b00, codes[i], codes[i], codes[i]});
            idle(2);
            `CHK("groups", {6{codes[i]}}, group_source)
        end
        wr(8'h07, 8'h1B);
        wr(8'h08, 8'h24);
        idle(2);
        `CHK("groups", {6'h24, 6'h1B}, group_source)
        // Halt gating by source field, own bit and global bit
        halt_source_select = {{7{4'h1}}, 4'h2, 4'h1, 4'h1};
        wr(8'h09, 8'h05);
        wr(8'h0A, 8'hFF);
        idle(3);
        `CHK("halt", halt_exp(10'h305, 1'b0), output_halt)
        `CHK("halt", 10'h301, output_halt)
        global_output_halt = 1'b1;
        idle(3);
        `CHK("halt", 10'h3FB, output_halt)
        wr(8'h09, 8'h00);
        wr(8'h0A, 8'h00);
        idle(3);
        `CHK("halt", 10'h3FB, output_halt)
        global_output_halt = 1'b0;
        idle(3);
        `CHK("halt", 10'h000, output_halt)
        // Pin state readable, inverted sense in mode 0001
        pin_in = 4'hA;
        wr(8'h0B, 8'h00);
        idle(3);
        rdchk(8'h41, 8'h0A);
        wr(8'h0B, 8'h01);
        idle(3);
        rdchk(8'h41, 8'h0B);
        wr(8'h0B, 8'h10);
        idle(3);
        rdchk(8'h41, 8'h08);
        // Every pin through every mode, following status bit 5 of 0x42
        for (p = 0; p < 4; p++) begin
            wr(8'h0D + p[7:0], 8'h15);
            rdchk(8'h0D + p[7:0], 8'h15);
            for (m = 0; m < 8; m++) begin
                for (s = 0; s < 2; s++) begin
                    status_bank = {{(STATUS_W-22){1'b0}}, s[0], 21'h0};
                    wr(8'h0B + p[7:1], 8'(m << (4 * (p % 2))));
                    idle(3);
                    eout = 1'b0;
                    case (m)
                        0, 1: eoe = 1'b0;
                        2: eoe = 1'b1;
                        3: {eoe, eout} = 2'b11;
                        4: {eoe, eout} = {1'b1, s[0]};
                        5: {eoe, eout} = {1'b1, ~s[0]};
                        6: eoe = ~s[0];
                        default: eoe = s[0];
                    endcase
                    `CHK($sformatf("oe p%0d m%0d", p, m), eoe, pin_oe[p])
                    if (eoe) begin
                        `CHK($sformatf("out p%0d m%0d", p, m), eout, pin_out[p])
                    end
                end
            end
            wr(8'h0B + p[7:1], 8'h00);
        end
        // Pin state and loop mask bits never followed
        status_bank = '1;
        wr(8'h0B, 8'h04);
        wr(8'h0D, 8'h08);
        idle(3);
        `CHK("out held low", 1'b0, pin_out[0])
        wr(8'h0D, 8'hF8);
        idle(3);
        `CHK("out held low", 1'b0, pin_out[0])
        // Second reset in mid-run clears the configured bank
        wr(8'h05, 8'hFF);
        pin_in = 4'h0;
        status_bank = '0;
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        idle(1);
        reset_chk();
        end_sim();
    end
endmodule // tb_top
